/* File: rtl/servo_index_guard_sector_gen.v */
// index, guard band and sector timing from the servo track
`include "servo_timing_defs.vh"
`default_nettype none

module servo_index_guard_sector_gen #(
  parameter PAT_W = `PAT_WIDTH,
  parameter BYTE_W = `BYTE_CNT_WIDTH,
  parameter GB_W = `GB_CNT_WIDTH,
  parameter KEY_W = 8
) (
  input wire clk,
  input wire rstn,
  input wire servo_pulse,
  input wire count_seven_strobe,
  input wire four_byte_tick,
  input wire two_byte_tick,
  input wire servo_bit_clock,
  input wire [KEY_W-1:0] sector_keys_low,
  input wire [KEY_W-1:0] sector_keys_high,
  output reg servo_pulse_latch,
  output reg index_pulse,
  output reg inner_band_a_pulse,
  output reg inner_band_b_pulse,
  output reg outer_band_pulse,
  output reg missing_bit_detect,
  output reg band_latch_clear,
  output wire inner_band_a_flag,
  output wire inner_band_b_flag,
  output wire outer_band_flag,
  output reg sector_pulse
);

  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  // counts cut on purpose to the widths of the counters that hold them
  localparam integer INDEX_TICKS_N = `INDEX_BYTES / `BYTES_PER_TICK;
  localparam integer SECTOR_CLKS_N = `SECTOR_BITS / `BITS_PER_BIT_CLK;
  localparam [1:0] INDEX_TICKS = INDEX_TICKS_N[1:0];
  localparam [4:0] SECTOR_CLKS = SECTOR_CLKS_N[4:0];

  // sector stretcher states, one hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_PULSE = 2'b10;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam SYNC_W = 5 + 2 * KEY_W;

  wire [SYNC_W-1:0] sync_v;

  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({sector_keys_high, sector_keys_low, servo_bit_clock,
               two_byte_tick, four_byte_tick, count_seven_strobe,
               servo_pulse}),
    .sync_out(sync_v)
  );

  wire svp_s = sync_v[0];
  wire cs7_s = sync_v[1];
  wire fbt_s = sync_v[2];
  wire tbt_s = sync_v[3];
  wire sbc_s = sync_v[4];
  wire [2*KEY_W-1:0] keys_s = sync_v[SYNC_W-1:5];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  // edges come from the synchronised copies, so each pin edge
  // yields exactly one clk cycle of rise
  reg [4:0] prev_q;

  always @(posedge clk) begin
    if (!rstn) begin
      prev_q <= 5'h00;
    end else begin
      prev_q <= sync_v[4:0];
    end
  end

  wire svp_rise = svp_s & ~prev_q[0];
  wire cs7_rise = cs7_s & ~prev_q[1];
  wire fbt_rise = fbt_s & ~prev_q[2];
  wire tbt_rise = tbt_s & ~prev_q[3];
  wire sbc_rise = sbc_s & ~prev_q[4];

  // ----------------------------------------
  // servo pulse latch and pattern register
  // ----------------------------------------
  // a servo pulse landing on the strobe edge is shifted in,
  // not dropped, since the clear and shift happen together
  reg [PAT_W-1:0] pat_q;
  reg shifted_q;

  always @(posedge clk) begin
    if (!rstn) begin
      servo_pulse_latch <= 1'b0;
      pat_q <= `PAT_RESET;
      shifted_q <= 1'b0;
    end else begin
      shifted_q <= cs7_rise;
      if (cs7_rise) begin
        servo_pulse_latch <= 1'b0;
        pat_q <= {pat_q[PAT_W-2:0], servo_pulse_latch | svp_rise};
      end else if (svp_rise) begin
        servo_pulse_latch <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // pattern decode
  // ----------------------------------------
  wire hit_index = shifted_q && (pat_q == `PAT_INDEX);
  wire hit_in_a = shifted_q && (pat_q == `PAT_INNER_A);
  wire hit_in_b = shifted_q && (pat_q == `PAT_INNER_B);
  wire hit_out = shifted_q && (pat_q == `PAT_OUTER);
  wire hit_band = hit_in_a | hit_in_b | hit_out;

  always @(posedge clk) begin
    if (!rstn) begin
      inner_band_a_pulse <= 1'b0;
      inner_band_b_pulse <= 1'b0;
      outer_band_pulse <= 1'b0;
      missing_bit_detect <= 1'b0;
    end else begin
      inner_band_a_pulse <= hit_in_a;
      inner_band_b_pulse <= hit_in_b;
      outer_band_pulse <= hit_out;
      missing_bit_detect <= hit_band;
    end
  end

  // ----------------------------------------
  // index stretcher
  // ----------------------------------------
  // index stands for four bytes, counted in two byte ticks
  reg [1:0] idx_cnt_q;
  reg [1:0] idx_cnt_d;
  reg index_d;

  // a fresh index mark restarts the count rather than adding to it
  always @* begin
    idx_cnt_d = idx_cnt_q;
    index_d = index_pulse;
    if (hit_index) begin
      idx_cnt_d = INDEX_TICKS;
      index_d = 1'b1;
    end else if (tbt_rise && idx_cnt_q != 2'h0) begin
      idx_cnt_d = idx_cnt_q - 2'h1;
      index_d = (idx_cnt_q != 2'h1);
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      idx_cnt_q <= 2'h0;
      index_pulse <= 1'b0;
    end else begin
      idx_cnt_q <= idx_cnt_d;
      index_pulse <= index_d;
    end
  end

  // ----------------------------------------
  // guard band reset counter
  // ----------------------------------------
  // idles at the top value; each missing bit reloads it, so it can
  // only run out once the head has left every guard band
  reg [GB_W-1:0] gb_cnt_q;
  reg [GB_W-1:0] gb_cnt_d;

  always @* begin
    gb_cnt_d = gb_cnt_q;
    if (missing_bit_detect) begin
      gb_cnt_d = `GB_LOAD;
    end else if (fbt_rise && gb_cnt_q != `GB_TOP) begin
      gb_cnt_d = gb_cnt_q + {{(GB_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      gb_cnt_q <= `GB_TOP;
      band_latch_clear <= 1'b0;
    end else begin
      gb_cnt_q <= gb_cnt_d;
      band_latch_clear <= (gb_cnt_d == `GB_TOP) && (gb_cnt_q != `GB_TOP);
    end
  end

  // ----------------------------------------
  // guard band filters
  // ----------------------------------------
  guard_band_filter u_filt_in_a (
    .clk(clk),
    .rstn(rstn),
    .band_pulse(inner_band_a_pulse),
    .band_clear(band_latch_clear),
    .band_flag(inner_band_a_flag)
  );

  guard_band_filter u_filt_in_b (
    .clk(clk),
    .rstn(rstn),
    .band_pulse(inner_band_b_pulse),
    .band_clear(band_latch_clear),
    .band_flag(inner_band_b_flag)
  );

  guard_band_filter u_filt_out (
    .clk(clk),
    .rstn(rstn),
    .band_pulse(outer_band_pulse),
    .band_clear(band_latch_clear),
    .band_flag(outer_band_flag)
  );

  // ----------------------------------------
  // byte counter
  // ----------------------------------------
  // keys that are on read as zero bits of the preset
  wire [BYTE_W-1:0] preset = ~keys_s[BYTE_W-1:0];
  reg [BYTE_W-1:0] byte_cnt_q;
  wire carry = (byte_cnt_q == `BYTE_CNT_TOP);
  wire preset_en = index_pulse | carry;

  always @(posedge clk) begin
    if (!rstn) begin
      byte_cnt_q <= `BYTE_CNT_RESET;
    end else if (tbt_rise) begin
      if (preset_en) begin
        byte_cnt_q <= preset;
      end else begin
        byte_cnt_q <= byte_cnt_q + {{(BYTE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------
  // sector stretcher
  // ----------------------------------------
  // the pulse width is counted on the servo bit clock, which carries
  // two bit cells per edge; a carry during the pulse is not restarted
  reg carry_q;
  reg [1:0] sec_st_q;
  reg [1:0] sec_st_d;
  reg [4:0] sec_cnt_q;
  reg [4:0] sec_cnt_d;
  reg sector_d;

  // a carry still high when the pulse ends does not start another one
  always @* begin
    sec_st_d = sec_st_q;
    sec_cnt_d = sec_cnt_q;
    sector_d = sector_pulse;
    case (sec_st_q)
      ST_IDLE: begin
        if (carry && !carry_q) begin
          sec_st_d = ST_PULSE;
          sec_cnt_d = SECTOR_CLKS;
          sector_d = 1'b1;
        end
      end
      ST_PULSE: begin
        if (sbc_rise) begin
          sec_cnt_d = sec_cnt_q - 5'h01;
          if (sec_cnt_q == 5'h01) begin
            sec_st_d = ST_IDLE;
            sector_d = 1'b0;
          end
        end
      end
      default: begin
        sec_st_d = ST_IDLE;
        sector_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      carry_q <= 1'b0;
      sec_st_q <= ST_IDLE;
      sec_cnt_q <= 5'h00;
      sector_pulse <= 1'b0;
    end else begin
      carry_q <= carry;
      sec_st_q <= sec_st_d;
      sec_cnt_q <= sec_cnt_d;
      sector_pulse <= sector_d;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/servo_timing_defs.vh */
// constants for the servo index, guard band and sector timing block
// Contract
// - latch sets on servo pulse, clears on strobe
// - strobe rising edge shifts latch into register
// - decode register into index and band pulses
// - first band pulse sets stage; counter loads 187
// - reset counter advances on four byte tick
// - second pulse before clear sets band flag
// - counter at 255 off band clears latches
// - byte counter clocked by two byte tick
// - preset is inverted sector keys, on equals zero
// - index pulse enables byte counter preset
// - increment on tick, carry at 65535
// - carry reloads preset for next sector
// - carry stretched into 24 bit sector pulse
// - band pulses and missing detect on bands
`ifndef SERVO_TIMING_DEFS_VH
`define SERVO_TIMING_DEFS_VH

// ----------------------------------------
// pattern shift register and decode
// ----------------------------------------
`define PAT_WIDTH 8
`define PAT_RESET 8'hff
`define PAT_INDEX 8'hee
`define PAT_INNER_A 8'hde
`define PAT_INNER_B 8'hbe
`define PAT_OUTER 8'h7e

// ----------------------------------------
// guard band reset counter
// ----------------------------------------
`define GB_CNT_WIDTH 8
`define GB_LOAD 8'hbb
`define GB_TOP 8'hff

// ----------------------------------------
// byte counter and pulse lengths
// ----------------------------------------
`define BYTE_CNT_WIDTH 16
`define BYTE_CNT_TOP 16'hffff
`define BYTE_CNT_RESET 16'h0000
`define BYTES_PER_REV 40960
`define BYTES_PER_TICK 2
`define INDEX_BYTES 4
`define SECTOR_BITS 24
`define BITS_PER_BIT_CLK 2

`endif

/* File: rtl/pin_sync.v */
// two flop synchroniser for a vector of pin inputs
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rstn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // first stage is read only by the second stage
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk) begin
    if (!rstn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/guard_band_filter.v */
// two stage flaw filter for one guard band
`default_nettype none

module guard_band_filter (
  input wire clk,
  input wire rstn,
  input wire band_pulse,
  input wire band_clear,
  output reg band_flag
);

  reg first_q;

  // ----------------------------------------
  // stages
  // ----------------------------------------
  // a lone pulse from a media flaw only reaches the first stage and
  // is wiped by the next clear; a pulse in the clear cycle still counts
  always @(posedge clk) begin
    if (!rstn) begin
      first_q <= 1'b0;
      band_flag <= 1'b0;
    end else begin
      if (band_pulse) begin
        first_q <= 1'b1;
      end else if (band_clear) begin
        first_q <= 1'b0;
      end
      if (band_pulse && first_q) begin
        band_flag <= 1'b1;
      end else if (band_clear) begin
        band_flag <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: tb/servo_osc_model.sv */
// oscillator-side model: servo pulses, strobes and byte ticks
`default_nettype none
module servo_osc_model (
  input wire logic clk,
  output var logic [4:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------
  // pin events
  // --------------------------------
  // bit 0 servo pulse, 1 strobe, 2 four byte tick, 3 two byte tick, 4 bit clock
  initial pins = 5'h00;
  // each level held 4 clocks: the pin sync needs 3, and idle is low between events
  task automatic hit(input int i);
    @(posedge clk);
    pins[i] <= 1'h1;
    repeat (4) @(posedge clk);
    pins[i] <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // a missing servo bit is a strobe without a pulse before it
  task automatic send_pat(input logic [7:0] p);
    for (int k = 7; k >= 0; k--) begin
      if (p[k]) hit(0);
      hit(1);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/servo_gen_chk.sv */
// assertion checker for the servo index, guard band and sector block
`default_nettype none
module servo_gen_chk (
  input wire clk,
  input wire rstn,
  input wire servo_pulse,
  input wire count_seven_strobe,
  input wire servo_pulse_latch,
  input wire index_pulse,
  input wire inner_band_a_pulse,
  input wire inner_band_b_pulse,
  input wire outer_band_pulse,
  input wire missing_bit_detect,
  input wire band_latch_clear,
  input wire inner_band_a_flag,
  input wire inner_band_b_flag,
  input wire outer_band_flag,
  input wire sector_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_sect_start;
    $rose(sector_pulse);
  endsequence
  sequence s_sect_long;
    sector_pulse[*8];
  endsequence
  a_latch_set: assert property ($rose(servo_pulse) |-> ##[2:3] servo_pulse_latch) else $error("latch not set");
  a_latch_clr: assert property ($rose(count_seven_strobe) |-> ##[2:3] !servo_pulse_latch) else $error("latch kept");
  a_miss_or: assert property (missing_bit_detect == (inner_band_a_pulse || inner_band_b_pulse || outer_band_pulse))
    else $error("missing detect differs");
  a_pulse_one: assert property (outer_band_pulse |=> !outer_band_pulse) else $error("band pulse long");
  a_clear_one: assert property (band_latch_clear |=> !band_latch_clear) else $error("clear long");
  a_flag_clear: assert property (band_latch_clear && !missing_bit_detect |=>
    !(inner_band_a_flag || inner_band_b_flag || outer_band_flag)) else $error("flag not cleared");
  a_flag_cause: assert property ($rose(inner_band_a_flag) |-> $past(inner_band_a_pulse)) else $error("flag no cause");
  a_sector_hold: assert property (s_sect_start |=> s_sect_long) else $error("sector short");
  a_index_hold: assert property ($rose(index_pulse) |=> index_pulse[*5]) else $error("index short");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the servo index, guard band and sector block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] keys_lo = 8'h00;
  logic [7:0] keys_hi = 8'h00;
  wire [4:0] pins;
  wire sl, ix, pa, pb, po, md, bc, fa, fb, fo, sp;
  wire [2:0] fl = {fa, fb, fo};
  logic [8:0] q[$];
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  int j;
  always #2 clk = ~clk;
  servo_osc_model pm (.clk(clk), .pins(pins));
  servo_index_guard_sector_gen dut (.clk(clk), .rstn(rstn), .servo_pulse(pins[0]), .count_seven_strobe(pins[1]),
    .four_byte_tick(pins[2]), .two_byte_tick(pins[3]), .servo_bit_clock(pins[4]), .sector_keys_low(keys_lo),
    .sector_keys_high(keys_hi), .servo_pulse_latch(sl), .index_pulse(ix), .inner_band_a_pulse(pa),
    .inner_band_b_pulse(pb), .outer_band_pulse(po), .missing_bit_detect(md), .band_latch_clear(bc),
    .inner_band_a_flag(fa), .inner_band_b_flag(fb), .outer_band_flag(fo), .sector_pulse(sp));
  // --------------------------------
  // checking
  // --------------------------------
  task automatic check(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // events only, not levels: flag and pulse widths are left to the checker
  always @(posedge clk) begin
    logic [8:0] ev;
    ev = {$rose(ix), $rose(pa), $rose(pb), $rose(po), $rose(bc), $rose(sp), $rose(fa), $rose(fb), $rose(fo)};
    cyc++;
    if (cyc == 45000) begin
      errors++;
      finish_test();
    end else if (rstn && ev != 9'h000) begin
      if (q.size() == 0) check(1'h0, "unexpected event");
      else check(ev === q.pop_front(), "event differs");
    end
  end
  initial begin
    logic [7:0] pat [3];
    pat = '{8'hde, 8'hbe, 8'h7e};
    j = $urandom(32'h2247);
    n = $urandom % 2047 + 1;
    repeat (8) @(posedge clk);
    check(sl === 1'h0 && ix === 1'h0 && sp === 1'h0 && fl === 3'h0 && bc === 1'h0, "reset values");
    rstn <= 1'h1;
    keys_lo <= n[7:0];
    keys_hi <= n[15:8];
    repeat (3) @(posedge clk);
    q.push_back(9'h100);
    pm.send_pat(8'hee);
    pm.send_pat(8'hff);
    j = 0;
    while (ix === 1'h1 && j < 4) begin
      pm.hit(3);
      j++;
    end
    check(j == 2, "index length");
    // keys on give zero bits, so the preset sits n below the carry
    for (int k = 0; k < 2; k++) begin
      q.push_back(9'h008);
      j = 0;
      while (sp !== 1'h1 && j < 2100) begin
        pm.hit(3);
        j++;
      end
      check(j == n + k, "sector spacing");
      j = 0;
      while (sp === 1'h1 && j < 20) begin
        pm.hit(4);
        j++;
      end
      check(j == 12, "sector length");
    end
    for (int i = 0; i < 3; i++) begin
      for (int r = 0; r < 2; r++) begin
        q.push_back(9'h080 >> i);
        if (r == 1) q.push_back(9'h004 >> i);
        pm.send_pat(pat[i]);
        pm.send_pat(8'hff);
      end
      q.push_back(9'h010);
      repeat (67) pm.hit(2);
      check(fl[2 - i] === 1'h1, "flag dropped early");
      pm.hit(2);
      check(fl === 3'h0, "flags not cleared");
    end
    // a lone pulse must not flag, and the clear must wipe the first stage too
    for (int r = 0; r < 2; r++) begin
      q.push_back(9'h080);
      pm.send_pat(8'hde);
      pm.send_pat(8'hff);
      check(fa === 1'h0, "single pulse flagged");
      if (r == 0) begin
        q.push_back(9'h010);
        repeat (68) pm.hit(2);
      end
    end
    repeat (8) @(posedge clk);
    check(q.size() == 0, "events missing");
    finish_test();
  end
endmodule
bind servo_index_guard_sector_gen servo_gen_chk u_chk (.clk, .rstn, .servo_pulse, .count_seven_strobe,
  .servo_pulse_latch, .index_pulse, .inner_band_a_pulse, .inner_band_b_pulse, .outer_band_pulse,
  .missing_bit_detect, .band_latch_clear, .inner_band_a_flag, .inner_band_b_flag, .outer_band_flag, .sector_pulse);
`default_nettype wire
